// ### rtl/ttac_consts.svh
`ifndef TTAC_CONSTS_SVH
`define TTAC_CONSTS_SVH

`define TTAC_CLK_HZ 20000000
// interval lengths in milliseconds
`define TTAC_STOP_REL_MS 100
`define TTAC_OPS_REL_MS 20
`define TTAC_BOOST_MS 200
`define TTAC_START_MS 1000
`define TTAC_KICK_MS 50
// cycle counts derived from the rate (rounded down, longest times)
`define TTAC_MS_CYC (`TTAC_CLK_HZ / 1000)
`define TTAC_STOP_REL_CYC (`TTAC_STOP_REL_MS * `TTAC_MS_CYC)
`define TTAC_OPS_REL_CYC (`TTAC_OPS_REL_MS * `TTAC_MS_CYC)
`define TTAC_BOOST_CYC (`TTAC_BOOST_MS * `TTAC_MS_CYC)
`define TTAC_START_CYC (`TTAC_START_MS * `TTAC_MS_CYC)
`define TTAC_KICK_CYC (`TTAC_KICK_MS * `TTAC_MS_CYC)

// apb register map
`define TTAC_REG_CTRL 12'h000
`define TTAC_REG_STATUS 12'h004
`define TTAC_REG_COUNT 12'h008
`define TTAC_CTRL_RESET 32'h0000_0000
`define TTAC_CTRL_REEL_BIT 0
`define TTAC_CTRL_CLR_BIT 1

`endif

// ### rtl/ttac_pkg.sv
package ttac_pkg;
   typedef struct packed {
      logic play;
      logic pause;
      logic record;
      logic reverse_wind_mode;
      logic fast_forward;
      logic fast_wind;
   } ttac_modes_s;

   typedef struct packed {
      logic capstan_sol;
      logic brake_sol;
      logic sol_boost;
      logic reel_hot_20v;
      logic reel_boost_24v;
      logic reel_hold_12v;
      logic right_drive_en;
      logic left_drive_en;
      logic right_kick;
      logic reel_bias_large;
      logic capstan_power;
   } ttac_drive_s;
endpackage : ttac_pkg

// ### rtl/ttac_actuator.sv
`include "ttac_consts.svh"

module ttac_actuator #(
   parameter int unsigned STOP_REL_CYC = `TTAC_STOP_REL_CYC,
   parameter int unsigned OPS_REL_CYC = `TTAC_OPS_REL_CYC,
   parameter int unsigned BOOST_CYC = `TTAC_BOOST_CYC,
   parameter int unsigned START_CYC = `TTAC_START_CYC,
   parameter int unsigned KICK_CYC = `TTAC_KICK_CYC,
   parameter int unsigned CNT_W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire ttac_pkg::ttac_modes_s mode_in,
   input wire logic first_photo_sensor,
   input wire logic second_photo_sensor,
   input wire logic arm_normal,
   input wire logic reel_size_selector,
   output logic stop_force,
   output logic ops_enable,
   output logic speed_fault,
   output ttac_pkg::ttac_drive_s drive,
   output logic direction_flip_flop,
   output logic count_up,
   output logic count_pulse,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import ttac_pkg::*;

   localparam int unsigned TW = 32;

   // a down-counter is live while cycles remain
   function automatic logic cnt_live(input logic [TW-1:0] cnt);
      return cnt != 32'h0;
   endfunction : cnt_live

   // the load edge already drives the output, so one cycle less is loaded
   function automatic logic [TW-1:0] cnt_load(input int unsigned cyc);
      if (cyc == 0)
         return 32'h0;
      return TW'(cyc - 1);
   endfunction : cnt_load

   // access phase of a transfer to one register
   function automatic logic apb_hit(input logic sel, input logic en,
                                    input logic [11:0] addr,
                                    input logic [11:0] reg_addr);
      return sel && en && addr == reg_addr;
   endfunction : apb_hit

   // synchronisers: first stage read only by the second
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_q <= 4'h0;
      end else begin
         sync1_q <= {reel_size_selector, arm_normal, second_photo_sensor,
                     first_photo_sensor};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync2_q <= 4'h0;
      end else begin
         sync2_q <= sync1_q;
      end
   end

   logic ch_a;
   logic ch_b;
   logic arm_ok;
   logic size_sel;
   assign ch_a = sync2_q[0];
   assign ch_b = sync2_q[1];
   assign arm_ok = sync2_q[2];
   assign size_sel = sync2_q[3];

   // power-up release timer, frozen once stop has cleared
   logic [TW-1:0] pwr_cnt_q;
   logic stop_hold_q;
   logic ops_hold_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pwr_cnt_q <= 32'h0;
      end else if (stop_hold_q) begin
         pwr_cnt_q <= pwr_cnt_q + 32'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ops_hold_q <= 1'b1;
      end else if (pwr_cnt_q >= TW'(OPS_REL_CYC)) begin
         ops_hold_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stop_hold_q <= 1'b1;
      end else if (pwr_cnt_q >= TW'(STOP_REL_CYC)) begin
         stop_hold_q <= 1'b0;
      end
   end

   // stop is the last to clear: operations stay held while stop holds
   assign ops_enable = !ops_hold_q && !stop_hold_q;
   assign stop_force = stop_hold_q || !arm_ok;
   assign speed_fault = !arm_ok;

   // effective modes: all operation requests masked while stopped
   ttac_modes_s m;
   logic play_m;
   logic wind_m;
   assign m = stop_force ? '0 : mode_in;
   assign play_m = m.play;
   assign wind_m = m.fast_forward | m.reverse_wind_mode | m.fast_wind;

   // solenoid pull-in detection; boost restarts on every pull-in
   logic cap_sol;
   logic brk_sol;
   logic cap_sol_q;
   logic brk_sol_q;
   logic pull_in;
   logic boost_on;
   logic [TW-1:0] boost_cnt_q;
   assign cap_sol = play_m;
   assign brk_sol = play_m | wind_m;
   assign pull_in = (cap_sol && !cap_sol_q) || (brk_sol && !brk_sol_q);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cap_sol_q <= 1'b0;
         brk_sol_q <= 1'b0;
      end else begin
         cap_sol_q <= cap_sol;
         brk_sol_q <= brk_sol;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         boost_cnt_q <= 32'h0;
      end else if (pull_in) begin
         boost_cnt_q <= cnt_load(BOOST_CYC);
      end else if (cnt_live(boost_cnt_q)) begin
         boost_cnt_q <= boost_cnt_q - 32'h1;
      end
   end
   // boost shows on the pull-in edge itself, not a cycle late
   assign boost_on = pull_in || cnt_live(boost_cnt_q);

   // reel start and right-reel kick timers, cleared when play ends
   logic play_q;
   logic play_rise;
   logic start_on;
   logic kick_on;
   logic [TW-1:0] start_cnt_q;
   logic [TW-1:0] kick_cnt_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         play_q <= 1'b0;
      end else begin
         play_q <= play_m;
      end
   end
   assign play_rise = play_m && !play_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         start_cnt_q <= 32'h0;
      end else if (play_rise) begin
         start_cnt_q <= cnt_load(START_CYC);
      end else if (!play_m) begin
         start_cnt_q <= 32'h0;
      end else if (cnt_live(start_cnt_q)) begin
         start_cnt_q <= start_cnt_q - 32'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         kick_cnt_q <= 32'h0;
      end else if (play_rise) begin
         kick_cnt_q <= cnt_load(KICK_CYC);
      end else if (!play_m) begin
         kick_cnt_q <= 32'h0;
      end else if (cnt_live(kick_cnt_q)) begin
         kick_cnt_q <= kick_cnt_q - 32'h1;
      end
   end
   assign start_on = play_m && (play_rise || cnt_live(start_cnt_q));
   assign kick_on = play_m && (play_rise || cnt_live(kick_cnt_q));

   // apb control register: reel size invert and counter clear
   logic [31:0] ctrl_q;
   logic [CNT_W-1:0] count_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= `TTAC_CTRL_RESET;
      end else if (pwrite
                   && apb_hit(psel, penable, paddr, `TTAC_REG_CTRL)) begin
         ctrl_q <= {31'h0, pwdata[`TTAC_CTRL_REEL_BIT]};
      end
   end

   // output drive registers, one concern to a block
   logic drv_cap_q;
   logic drv_brk_q;
   logic drv_boost_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drv_cap_q <= 1'b0;
         drv_brk_q <= 1'b0;
         drv_boost_q <= 1'b0;
      end else begin
         drv_cap_q <= cap_sol;
         drv_brk_q <= brk_sol;
         drv_boost_q <= (cap_sol | brk_sol) && boost_on;
      end
   end

   // reel supplies: 20 V standby, 24 V start, 12 V steady
   logic drv_hot_q;
   logic drv_r24_q;
   logic drv_r12_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drv_hot_q <= 1'b0;
         drv_r24_q <= 1'b0;
         drv_r12_q <= 1'b0;
      end else begin
         drv_hot_q <= !play_m;
         drv_r24_q <= start_on;
         drv_r12_q <= play_m && !start_on;
      end
   end

   // reel drive returns stay open until play
   logic drv_ren_q;
   logic drv_len_q;
   logic drv_kick_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drv_ren_q <= 1'b0;
         drv_len_q <= 1'b0;
         drv_kick_q <= 1'b0;
      end else begin
         drv_ren_q <= play_m;
         drv_len_q <= play_m;
         drv_kick_q <= kick_on;
      end
   end

   logic drv_bias_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drv_bias_q <= 1'b0;
      end else begin
         drv_bias_q <= size_sel ^ ctrl_q[`TTAC_CTRL_REEL_BIT];
      end
   end

   logic drv_cpwr_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         drv_cpwr_q <= 1'b0;
      end else begin
         drv_cpwr_q <= arm_ok;
      end
   end

   assign drive = '{capstan_sol: drv_cap_q, brake_sol: drv_brk_q,
      sol_boost: drv_boost_q, reel_hot_20v: drv_hot_q,
      reel_boost_24v: drv_r24_q, reel_hold_12v: drv_r12_q,
      right_drive_en: drv_ren_q, left_drive_en: drv_len_q,
      right_kick: drv_kick_q, reel_bias_large: drv_bias_q,
      capstan_power: drv_cpwr_q};

   // quadrature: rising edge of channel one samples channel two
   logic ch_a_q;
   logic a_rise;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ch_a_q <= 1'b0;
      end else begin
         ch_a_q <= ch_a;
      end
   end
   assign a_rise = ch_a && !ch_a_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         direction_flip_flop <= 1'b1;
      end else if (a_rise) begin
         // channel two low at channel one rise means forward
         direction_flip_flop <= !ch_b;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_pulse <= 1'b0;
      end else begin
         count_pulse <= a_rise;
      end
   end
   assign count_up = direction_flip_flop;

   // local tape count; a clear in the same cycle as a pulse wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_q <= '0;
      end else if (pwrite && pwdata[`TTAC_CTRL_CLR_BIT]
                   && apb_hit(psel, penable, paddr, `TTAC_REG_CTRL)) begin
         count_q <= '0;
      end else if (count_pulse) begin
         if (count_up) begin
            count_q <= count_q + CNT_W'(1);
         end else begin
            count_q <= count_q - CNT_W'(1);
         end
      end
   end

   // apb slave, zero wait states
   logic addr_ok;
   assign pready = 1'b1;
   assign addr_ok = paddr == `TTAC_REG_CTRL || paddr == `TTAC_REG_STATUS
                    || paddr == `TTAC_REG_COUNT;
   assign pslverr = psel && penable && !addr_ok;

   always_comb begin
      prdata = 32'h0;
      if (psel && !pwrite) begin
         unique case (paddr)
            `TTAC_REG_CTRL: prdata = ctrl_q;
            `TTAC_REG_STATUS: prdata = {25'h0, direction_flip_flop,
               speed_fault, ops_enable, stop_force, drive.sol_boost,
               drive.reel_boost_24v, play_m};
            `TTAC_REG_COUNT: prdata = {{(32 - CNT_W){1'b0}}, count_q};
            default: prdata = 32'h0;
         endcase
      end
   end
endmodule : ttac_actuator

// ### tb/ttac_actuator_sva.sv
module ttac_actuator_sva
   import ttac_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire ttac_pkg::ttac_modes_s mode_in,
   input wire logic arm_normal,
   input wire logic stop_force,
   input wire logic speed_fault,
   input wire ttac_pkg::ttac_drive_s drive,
   input wire logic direction_flip_flop,
   input wire logic count_up,
   input wire logic count_pulse
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // five cycles covers the two sync flops plus the drive register
   property p_arm_bad;
      !arm_normal [*5] |-> stop_force && speed_fault && !drive.capstan_power;
   endproperty
   a_arm_bad: assert property (p_arm_bad) else $error("arm fault");
   property p_arm_ok;
      arm_normal [*5] |-> !speed_fault && drive.capstan_power;
   endproperty
   a_arm_ok: assert property (p_arm_ok) else $error("arm ok");
   property p_stop;
      stop_force |=> !drive.capstan_sol && !drive.brake_sol;
   endproperty
   a_stop: assert property (p_stop) else $error("stop");
   property p_play;
      mode_in == 6'h20 && !stop_force |=> drive.capstan_sol;
   endproperty
   a_play: assert property (p_play) else $error("play");
   property p_pause;
      mode_in == 6'h10 |=> !drive.capstan_sol && !drive.brake_sol;
   endproperty
   a_pause: assert property (p_pause) else $error("pause");
   property p_boost;
      $rose(drive.sol_boost) |-> drive.sol_boost [*8] ##[1:4] !drive.sol_boost;
   endproperty
   a_boost: assert property (p_boost) else $error("boost");
   property p_start;
      $rose(drive.right_drive_en) && drive.capstan_sol
         |-> drive.reel_boost_24v && drive.right_kick && !drive.reel_hot_20v;
   endproperty
   a_start: assert property (p_start) else $error("start");
   property p_pulse;
      count_pulse |=> !count_pulse && count_up == direction_flip_flop;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse");
   c_boost: cover property ($rose(drive.sol_boost));
   c_rev: cover property (count_pulse && !count_up);
   c_fault: cover property (speed_fault);
endmodule : ttac_actuator_sva

// ### tb/ttac_sensor_model.sv
module ttac_sensor_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic run,
   input wire logic fwd,
   input wire logic fast,
   output logic ch1,
   output logic ch2
);
   logic [1:0] ph_q;
   logic [2:0] div_q;
   // disc steps a quarter slot every 2 (fast) or 8 (slow) cycles
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph_q <= 2'h0;
         div_q <= 3'h0;
      end else if (run) begin
         div_q <= div_q + 3'h1;
         if (fast ? div_q[0] : div_q == 3'h7) begin
            ph_q <= fwd ? ph_q + 2'h1 : ph_q - 2'h1;
         end
      end
   end
   assign ch1 = ph_q[1] ^ ph_q[0];
   assign ch2 = ph_q[1];
endmodule : ttac_sensor_model

// ### tb/ttac_actuator_tb.sv
module ttac_actuator_tb
   import ttac_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, ch1, ch2, arm_normal, sel, run, fwd, err;
   logic psel, penable, pwrite, stop_force, ops_enable, speed_fault;
   logic direction_flip_flop, count_up, count_pulse, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   ttac_modes_s mode_in;
   ttac_drive_s drive;
   int fails, checked;
   // {mode, capstan, brake}: play, pause, fwd wind, reverse wind, stop
   logic [7:0] rows [5] = '{8'h83, 8'h40, 8'h09, 8'h11, 8'h00};
   ttac_actuator #(.STOP_REL_CYC(100), .OPS_REL_CYC(20), .BOOST_CYC(10),
      .START_CYC(30), .KICK_CYC(5)) ttac_actuator_inst (.clk, .rst, .mode_in,
      .first_photo_sensor(ch1), .second_photo_sensor(ch2), .arm_normal,
      .reel_size_selector(sel), .stop_force, .ops_enable, .speed_fault,
      .drive, .direction_flip_flop, .count_up, .count_pulse, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   ttac_sensor_model ttac_sensor_model_inst (.clk, .rst, .run, .fwd,
      .fast(fwd), .ch1, .ch2);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task wrap_up;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      if (i == 50) begin
         fails++;
         wrap_up();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   initial begin
      cyc(20000);
      fails++;
      wrap_up();
   end
   initial begin
      int i;
      logic [31:0] c;
      {rst, arm_normal, sel, run, fwd, psel, penable, pwrite} = 8'hc8;
      {mode_in, paddr, pwdata} = '0;
      cyc(5);
      chk({stop_force, drive}, 12'h800);
      rst <= 1'b0;
      mode_in <= 6'h20;
      cyc(60);
      chk({stop_force, ops_enable, drive.capstan_sol}, 3'h4);
      for (i = 0; i < 300 && stop_force !== 1'b0; i++) @(posedge clk);
      chk(i > 30 && i < 300, 1);
      cyc(2);
      chk({drive.sol_boost, drive.reel_boost_24v, drive.right_kick,
         drive.reel_hot_20v, drive.left_drive_en}, 5'h1d);
      cyc(12);
      chk({drive.sol_boost, drive.right_kick, drive.capstan_sol}, 3'h1);
      cyc(25);
      chk({drive.reel_boost_24v, drive.reel_hold_12v}, 2'h1);
      $display("power-up and play done");
      foreach (rows[k]) begin
         mode_in <= rows[k][7:2];
         cyc(15);
         chk({drive.capstan_sol, drive.brake_sol}, rows[k][1:0]);
      end
      chk({drive.reel_hot_20v, drive.right_drive_en}, 2'h2);
      $display("mode table done");
      mode_in <= 6'h20;
      sel <= 1'b1;
      cyc(5);
      chk(drive.reel_bias_large, 1);
      apb(1'b1, 12'h000, 32'h1);
      cyc(2);
      chk(drive.reel_bias_large, 0);
      apb(1'b0, 12'h00c, 32'h0);
      chk({err, rd[3:0]}, 5'h10);
      $display("register checks done");
      apb(1'b1, 12'h000, 32'h3);
      run <= 1'b1;
      cyc(60);
      chk({direction_flip_flop, count_up}, 2'h3);
      apb(1'b0, 12'h008, 32'h0);
      c = rd;
      cyc(40);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[15:0] > c[15:0], 1);
      fwd <= 1'b0;
      cyc(100);
      chk({direction_flip_flop, count_up}, 2'h0);
      c = rd;
      cyc(100);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[15:0] < c[15:0], 1);
      $display("sensor checks done");
      arm_normal <= 1'b0;
      cyc(6);
      chk({stop_force, speed_fault, drive.capstan_power}, 3'h6);
      arm_normal <= 1'b1;
      cyc(6);
      chk({stop_force, speed_fault, drive.capstan_power}, 3'h1);
      rst <= 1'b1;
      cyc(2);
      chk({stop_force, drive}, 12'h800);
      rst <= 1'b0;
      cyc(3);
      chk({stop_force, ops_enable, drive.capstan_sol}, 3'h4);
      $display("arm and reset checks done");
      wrap_up();
   end
endmodule : ttac_actuator_tb

bind ttac_actuator ttac_actuator_sva ttac_actuator_sva_inst (.clk, .rst,
   .mode_in, .arm_normal, .stop_force, .speed_fault, .drive,
   .direction_flip_flop, .count_up, .count_pulse);
